/* link_clk_pkg.sv */
package link_clk_pkg;
  // Lane geometry and idle/compensation symbols
  localparam int LANES_DEF = 2;
  localparam int WORD_W = 16;
  localparam logic [WORD_W-1:0] IDLE_WORD = 16'hBC50;
  localparam logic [WORD_W-1:0] COMP_WORD = 16'hF7F7;
  localparam logic [1:0] KIND_IDLE = 2'h0;
  localparam logic [1:0] KIND_DATA = 2'h1;
  localparam logic [1:0] KIND_FLOW = 2'h2;
  localparam logic [1:0] KIND_COMP = 2'h3;

  // User data word offered for transmission
  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] data;
  } user_word_s;

  // Transmit lane word with its kind marker
  typedef struct packed {
    logic [1:0] kind;
    logic [WORD_W-1:0] data;
  } lane_word_s;

  // Transmitter mux states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FLOW = 3'b010,
    ST_COMP = 3'b100
  } tx_state_e;
endpackage : link_clk_pkg

/* link_clocking_and_clock_comp.sv */
// Functional notes
// R01 - Surroundings drive pll-unlocked input as inverse of the PLL lock.
// R02 - Without a PLL, surroundings hold pll-unlocked input low.
// R03 - Fabric and sync clocks come from PLL or global buffer off transmit clock.
// R04 - Fabric clock is shared with user and forwarded as secondary user clock.
// R05 - Sync clock is forwarded to the transceiver as primary user clock.
// R06 - Compensation inputs exist only in transmitting configurations; here the ports exist always and are ignored when TX_CAPABLE is 0.
// R07 - While compensation requested, user data and flow messages are halted.
// R08 - Every requested cycle sends compensation sequences on all lanes together.
// R09 - While warning is high, user flow message requests are not acknowledged.
// R10 - A separate manager schedules compensation request and warning.
// R11 - With a shared physical clock both compensation inputs are tied low.
// R12 - Signals between user and device should be registered; o_user_ready is driven combinationally from reset and the compensation request.
// R13 - After request falls, traffic resumes next cycle without loss or duplication.
`timescale 1ns/1ps
module link_clocking_and_clock_comp #(
  parameter int LANES = link_clk_pkg::LANES_DEF,
  parameter bit TX_CAPABLE = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_sync_clk,
  input wire logic i_serial_reference_clock,
  input wire logic i_pll_not_locked,
  input wire logic i_compensation_request_in,
  input wire logic i_compensation_warning_in,
  input wire link_clk_pkg::user_word_s i_user_word,
  output logic o_user_ready,
  input wire logic i_user_flow_message_req,
  input wire logic [link_clk_pkg::WORD_W-1:0] i_user_flow_message,
  output logic o_user_flow_message_ack,
  output logic o_user_clk,
  output logic o_xcvr_secondary_user_clock,
  output logic o_xcvr_primary_user_clock,
  output logic o_xcvr_reference_clock,
  output link_clk_pkg::lane_word_s [LANES-1:0] o_lane_word,
  output logic o_link_clock_ok
);
  // R04 fabric clock shared
  assign o_user_clk = i_sys_clk;
  assign o_xcvr_secondary_user_clock = i_sys_clk;
  // R05 sync clock forwarded
  assign o_xcvr_primary_user_clock = i_sync_clk;
  assign o_xcvr_reference_clock = i_serial_reference_clock;

  // Lock status resynchronised onto the fabric clock
  logic lock_meta_q, lock_sync_q;
  logic lock_meta_d, lock_sync_d;
  // Compensation inputs, only used when the block transmits
  logic comp_req, comp_warn;
  // R06 transmit-only compensation
  assign comp_req = TX_CAPABLE ? i_compensation_request_in : 1'b0;
  assign comp_warn = TX_CAPABLE ? i_compensation_warning_in : 1'b0;

  // Next values of the two lock flops
  always_comb begin
    lock_meta_d = ~i_pll_not_locked;
    lock_sync_d = lock_meta_q;
  end

  // Lock flops, cleared so the link reads unlocked during reset
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      lock_meta_q <= 1'b0;
      lock_sync_q <= 1'b0;
    end else begin
      lock_meta_q <= lock_meta_d;
      lock_sync_q <= lock_sync_d;
    end
  end
  assign o_link_clock_ok = lock_sync_q;

  // Transmit mux state
  link_clk_pkg::tx_state_e state_q, state_d;
  link_clk_pkg::lane_word_s [LANES-1:0] lane_q, lane_d;
  logic ack_d, ack_q;

  // Handshakes: data accepted only when not compensating
  // R07 halt user data
  assign o_user_ready = i_rst_n & ~comp_req;
  // R13 resume without loss
  logic take_data;
  assign take_data = o_user_ready & i_user_word.valid;
  logic take_flow;
  // R09 warning blocks acknowledge
  assign take_flow = i_rst_n & ~comp_req & ~comp_warn & i_user_flow_message_req & ~i_user_word.valid & ~ack_q;
  assign o_user_flow_message_ack = ack_q;

  // Next lane words and state
  always_comb begin
    state_d = link_clk_pkg::ST_IDLE;
    ack_d = take_flow;
    for (int i = 0; i < LANES; i++) begin
      lane_d[i] = '{kind: link_clk_pkg::KIND_IDLE, data: link_clk_pkg::IDLE_WORD};
    end
    case (1'b1)
      // R08 all lanes compensate
      comp_req: begin
        state_d = link_clk_pkg::ST_COMP;
        for (int i = 0; i < LANES; i++) begin
          lane_d[i] = '{kind: link_clk_pkg::KIND_COMP, data: link_clk_pkg::COMP_WORD};
        end
      end
      take_data: begin
        state_d = link_clk_pkg::ST_IDLE;
        for (int i = 0; i < LANES; i++) begin
          lane_d[i] = '{kind: link_clk_pkg::KIND_DATA, data: i_user_word.data};
        end
      end
      take_flow: begin
        state_d = link_clk_pkg::ST_FLOW;
        for (int i = 0; i < LANES; i++) begin
          lane_d[i] = '{kind: link_clk_pkg::KIND_FLOW, data: i_user_flow_message};
        end
      end
      default: begin
        state_d = link_clk_pkg::ST_IDLE;
      end
    endcase
  end

  // Lane, state and acknowledge registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_q <= link_clk_pkg::ST_IDLE;
      ack_q <= 1'b0;
      for (int i = 0; i < LANES; i++) begin
        lane_q[i] <= '{kind: link_clk_pkg::KIND_IDLE, data: link_clk_pkg::IDLE_WORD};
      end
    end else begin
      state_q <= state_d;
      ack_q <= ack_d;
      lane_q <= lane_d;
    end
  end
  assign o_lane_word = lane_q;

  // Checks on the transmit side
  // R08 first and last lanes compensate
  property p_comp_all_lanes;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    comp_req |=> (lane_q[0].kind == link_clk_pkg::KIND_COMP) && (lane_q[LANES-1].kind == link_clk_pkg::KIND_COMP);
  endproperty
  a_comp_all_lanes: assert property (p_comp_all_lanes) else $error("lanes not compensating"); // R08

  // R07 traffic halted
  property p_no_ready_in_comp;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    comp_req |-> !o_user_ready ##1 ((lane_q[0].kind != link_clk_pkg::KIND_DATA)
      && (lane_q[0].kind != link_clk_pkg::KIND_FLOW));
  endproperty
  a_no_ready_in_comp: assert property (p_no_ready_in_comp) else $error("data accepted during compensation"); // R07

  // R09 acknowledge withheld
  property p_warn_no_ack;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (comp_warn || comp_req) |=> !o_user_flow_message_ack;
  endproperty
  a_warn_no_ack: assert property (p_warn_no_ack) else $error("flow ack under warning"); // R09

  // R13 traffic resumes
  property p_resume;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    $fell(comp_req) && i_user_word.valid |=> lane_q[0].kind == link_clk_pkg::KIND_DATA
      && lane_q[0].data == $past(i_user_word.data);
  endproperty
  a_resume: assert property (p_resume) else $error("data not resumed"); // R13

  // R04 fabric clock shared
  property p_clk_fwd;
    @(posedge i_sys_clk) o_xcvr_secondary_user_clock == o_user_clk;
  endproperty
  a_clk_fwd: assert property (p_clk_fwd) else $error("clock not forwarded"); // R04

  // R05 sync clock forwarded
  property p_primary_fwd;
    @(posedge i_sys_clk) o_xcvr_primary_user_clock == i_sync_clk;
  endproperty
  a_primary_fwd: assert property (p_primary_fwd) else $error("sync clock not forwarded"); // R05

  // R06 receive-only quiet
  property p_rx_only;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    !TX_CAPABLE |=> lane_q[0].kind != link_clk_pkg::KIND_COMP;
  endproperty
  a_rx_only: assert property (p_rx_only) else $error("compensation in receive-only"); // R06

  // R13 word kept
  property p_data_kept;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    take_data |=> lane_q[0].data == $past(i_user_word.data) ##1 1'b1;
  endproperty
  a_data_kept: assert property (p_data_kept) else $error("data word lost"); // R13

  // R08 lanes identical
  logic lanes_same;
  always_comb begin
    lanes_same = 1'b1;
    for (int i = 1; i < LANES; i++) begin
      if (lane_q[i] != lane_q[0]) begin
        lanes_same = 1'b0;
      end
    end
  end
  property p_lanes_same;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    lanes_same;
  endproperty
  a_lanes_same: assert property (p_lanes_same) else $error("lanes carry different words"); // R08

  // R08 state matches lanes
  property p_state_lanes;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (state_q == link_clk_pkg::ST_COMP) == (lane_q[0].kind == link_clk_pkg::KIND_COMP)
      && (state_q == link_clk_pkg::ST_FLOW) == (lane_q[0].kind == link_clk_pkg::KIND_FLOW);
  endproperty
  a_state_lanes: assert property (p_state_lanes) else $error("state and lane kind disagree"); // R08

  // R01 lock loss reported
  property p_lock_loss;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_pll_not_locked |-> ##2 !o_link_clock_ok;
  endproperty
  a_lock_loss: assert property (p_lock_loss) else $error("lock loss not reported"); // R01

  // Main scenarios
  c_comp: cover property (@(posedge i_sys_clk) comp_req ##1 !comp_req);
  c_flow: cover property (@(posedge i_sys_clk) o_user_flow_message_ack);
  c_data: cover property (@(posedge i_sys_clk) take_data ##1 comp_req);
  c_lock: cover property (@(posedge i_sys_clk) i_pll_not_locked ##1 !i_pll_not_locked);
endmodule : link_clocking_and_clock_comp

/* cc_mgr_model.sv */
`timescale 1ns/1ps
module cc_mgr_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_quiet,
  output logic o_req,
  output logic o_warn
);
  logic [4:0] cnt_q;
  // Schedule counter
  always_ff @(posedge i_clk) cnt_q <= i_rst_n ? cnt_q + 5'h01 : 5'h00;
  assign o_warn = !i_quiet && cnt_q < 5'h08;
  assign o_req = !i_quiet && cnt_q > 5'h03 && cnt_q < 5'h08;
endmodule : cc_mgr_model

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, sy = 0, rc = 0, rst_n = 0, quiet = 0, req, warn, rdy, f_req = 0, ack, ok;
  logic uc, c2, c1, rco;
  logic [15:0] f_msg = 16'h0000;
  link_clk_pkg::user_word_s uw = '0;
  link_clk_pkg::lane_word_s [1:0] lw;
  link_clk_pkg::lane_word_s [1:0] lw_rx;
  logic pnl = 0, k1 = 0, k2 = 0, rdy_rx, ok_rx;
  link_clk_pkg::lane_word_s e;
  link_clk_pkg::lane_word_s q[$];
  logic exp_ack = 0;
  int seed = 59, fail_count = 0, checked = 0, cyc = 0;
  // clocks from sources
  // Clocks at unrelated periods, all starting low
  initial forever #25 clk = ~clk;
  initial forever #19 sy = ~sy;
  initial forever #7 rc = ~rc;
  cc_mgr_model mgr (.i_clk(clk), .i_rst_n(rst_n), .i_quiet(quiet), .o_req(req), .o_warn(warn));
  link_clocking_and_clock_comp #(.TX_CAPABLE(1'b0)) dut_rx (.i_sys_clk(clk), .i_rst_n(rst_n), .i_sync_clk(sy),
    .i_serial_reference_clock(rc), .i_pll_not_locked(1'b0), .i_compensation_request_in(req),
    .i_compensation_warning_in(warn), .i_user_word(uw), .o_user_ready(rdy_rx),
    .i_user_flow_message_req(f_req), .i_user_flow_message(f_msg), .o_user_flow_message_ack(),
    .o_user_clk(), .o_xcvr_secondary_user_clock(), .o_xcvr_primary_user_clock(),
    .o_xcvr_reference_clock(), .o_lane_word(lw_rx), .o_link_clock_ok(ok_rx));
  link_clocking_and_clock_comp dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_sync_clk(sy),
    .i_serial_reference_clock(rc), .i_pll_not_locked(pnl), .i_compensation_request_in(req),
    .i_compensation_warning_in(warn), .i_user_word(uw), .o_user_ready(rdy),
    .i_user_flow_message_req(f_req), .i_user_flow_message(f_msg), .o_user_flow_message_ack(ack),
    .o_user_clk(uc), .o_xcvr_secondary_user_clock(c2), .o_xcvr_primary_user_clock(c1),
    .o_xcvr_reference_clock(rco), .o_lane_word(lw), .o_link_clock_ok(ok));
  // Compare and count
  task chk(input string nm, input logic [17:0] s, input logic [17:0] x);
    checked++;
    if (s !== x) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", nm, x, s);
    end
  endtask : chk
  // Verdict
  task results;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // Forwarded clocks, looked at once each edge has settled
  always @(clk) #1 chk("uclk", {uc, c2}, {clk, clk});
  always @(sy) #1 chk("pclk", c1, sy);
  always @(rc) #1 chk("rclk", rco, rc);
  // Model, compare and drive
  always @(posedge clk) begin
    cyc++;
    if (cyc > 1) begin
      e = q.pop_front();
      for (int i = 0; i < 2; i++) chk("lane", lw[i], e);
      chk("ack", ack, exp_ack);
      if (cyc > 10) chk("ready", rdy, !req && rst_n);
      chk("clock_ok", ok, k2);
      chk("rx_comp", lw_rx[0].kind == link_clk_pkg::KIND_COMP, 1'b0);
      chk("rx_ready", rdy_rx, rst_n);
    end
    // Two-flop lock pipeline expected from the unlock input
    k2 = rst_n && k1;
    k1 = rst_n && !pnl;
    e = {link_clk_pkg::KIND_IDLE, link_clk_pkg::IDLE_WORD};
    if (rst_n && req) e = {link_clk_pkg::KIND_COMP, link_clk_pkg::COMP_WORD};
    else if (rst_n && uw.valid) e = {link_clk_pkg::KIND_DATA, uw.data};
    else if (rst_n && f_req && !warn && !exp_ack) e = {link_clk_pkg::KIND_FLOW, f_msg};
    exp_ack = (e.kind === link_clk_pkg::KIND_FLOW);
    q.push_back(e);
    if (!uw.valid || (rdy && rst_n)) begin
      uw.valid <= ($random(seed) % 3) != 0;
      uw.data <= 16'($random(seed));
    end
    if (ack) f_req <= 1'b0;
    else if (!f_req) begin
      f_req <= ($random(seed) % 2) != 0;
      f_msg <= 16'($random(seed));
    end
    if (cyc > 3000) begin
      fail_count++;
      results();
    end
  end
  // Reset, busy phase, quiet phase
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (700) @(posedge clk);
    pnl <= 1'b1;
    repeat (20) @(posedge clk);
    pnl <= 1'b0;
    repeat (780) @(posedge clk);
    quiet <= 1'b1;
    repeat (300) @(posedge clk);
    chk("clock_ok", ok, 1'b1);
    chk("rx_clock_ok", ok_rx, 1'b1);
    results();
  end
endmodule : tb_top
